// ==== hdl/pport_host_mux.sv ====
// Purpose: four-port parallel host multiplexer onto one shared bus
// Assumes: external latches capture bus on rising latch clocks
// Notes:   only host role; peripheral role is not provided
`include "pport_map.svh"
module pport_host_mux #(
    parameter int NPORT      = 4,
    parameter int STROBE_CYC = `STROBE_CYC
) (
    input  wire logic                        clk,         // System clock
    input  wire logic                        rst_n,       // Async reset, low
    input  wire logic [2:0]                  interface_style_field, // Style
    input  wire pport_pkg::port_cfg_t        cfg [NPORT], // Per-port config
    input  wire logic [NPORT-1:0]            busy,        // Peripheral busy
    input  wire logic [NPORT-1:0]            wr_valid,    // DMA word write
    input  wire logic [31:0]                 wr_data,     // DMA word data
    output logic [NPORT-1:0]                 dma_req,     // Word request
    output logic                             parallel_pins_sel, // Pin set
    output logic                             host_modes_en, // RAM/FIFO modes
    output logic [7:0]                       bus_o,       // Shared bus out
    output logic                             bus_oe,      // Shared bus enable
    input  wire logic [7:0]                  bus_i,       // Shared bus in
    output logic [NPORT-1:0]                 data_clk,    // Data latch clocks
    output logic [NPORT-1:0]                 ctl_clk,     // Ctl latch clocks
    output logic [NPORT-1:0]                 in_oe_n,     // Inbound enables
    output logic [NPORT-1:0][7:0]            in_data      // Inbound bytes
);
    logic                   par_en;
    logic [NPORT-1:0]       served;
    logic [NPORT-1:0][7:0]  pdat;
    logic [NPORT-1:0]       pstb_n;
    pport_pkg::phase_t      ph_ff, nxt_ph;
    logic [1:0]             sel_ff, nxt_sel;
    logic [7:0]             bus_ff, nxt_bus;
    logic                   oe_ff, nxt_oe;
    logic [NPORT-1:0]       dclk_ff, nxt_dclk, cclk_ff, nxt_cclk, ioe_ff, nxt_ioe;
    logic [NPORT-1:0][7:0]  ind_ff, nxt_ind;

    // One style at a time; parallel disables the host modes
    assign par_en            = interface_style_field == `STYLE_PARALLEL; // see (RULE_01)
    assign parallel_pins_sel = par_en;                   // see (RULE_02)
    assign host_modes_en     = !par_en;                  // see (RULE_03)

    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
        assign served[p] = par_en && ph_ff == pport_pkg::ST_HOLD && sel_ff == 2'(p);
        pport_chan #(.STROBE_CYC(STROBE_CYC)) u_chan (   // see (RULE_04) (RULE_14)
            .clk      (clk),
            .rst_n    (rst_n),
            .enable   (par_en),
            .cfg      (cfg[p]),
            .busy     (busy[p]),
            .wr_valid (wr_valid[p]),
            .wr_data  (wr_data),
            .dma_req  (dma_req[p]),
            .served   (served[p]),
            .data_out (pdat[p]),
            .strobe_n (pstb_n[p])
        );
    end

    function automatic logic [7:0] ctl_byte(pport_pkg::port_cfg_t c, logic stb_n);
        logic [7:0] b;
        b = 8'h0;
        b[`CTL_STROBE_BIT] = stb_n;                      // see (RULE_07)
        b[`CTL_AUTO_LINE_FEED_N_BIT] = c.auto_line_feed_n;
        b[`CTL_INIT_BIT]   = c.init_n;
        b[`CTL_HSEL_BIT]   = c.host_select_in_n;
        b[`CTL_DIR_BIT]    = c.mode.reverse;             // see (RULE_08)
        b[`CTL_FWOUT_BIT]  = c.fw_out;                   // see (RULE_09)
        b[`CTL_WRAP_BIT]   = c.wrap_sel;                 // see (RULE_10)
        b[`CTL_CAPT_BIT]   = !stb_n;                     // see (RULE_11)
        return b;
    endfunction

    // Per port: data setup, data clock, control setup, control clock,
    // then a read window when reverse direction is set.
    always_comb
    begin
        nxt_ph   = ph_ff;
        nxt_sel  = sel_ff;
        nxt_bus  = bus_ff;
        nxt_oe   = oe_ff;
        nxt_dclk = '0;
        nxt_cclk = '0;
        nxt_ioe  = '1;
        nxt_ind  = ind_ff;
        case (ph_ff)
            pport_pkg::ST_IDLE:
            begin
                nxt_bus = pdat[sel_ff];                  // see (RULE_07)
                nxt_oe  = par_en;
                if (par_en)
                    nxt_ph = pport_pkg::ST_SETUP;
            end
            pport_pkg::ST_SETUP:
            begin
                nxt_dclk[sel_ff] = 1'b1;                 // see (RULE_06) (RULE_16)
                nxt_ph = pport_pkg::ST_CLK;
            end
            pport_pkg::ST_CLK:
            begin
                nxt_bus = ctl_byte(cfg[sel_ff], pstb_n[sel_ff]);
                nxt_ph  = pport_pkg::ST_HOLD;
            end
            pport_pkg::ST_HOLD:
            begin
                nxt_cclk[sel_ff] = 1'b1;                 // see (RULE_06) (RULE_16)
                if (cfg[sel_ff].mode.reverse)
                begin
                    nxt_ph = pport_pkg::ST_RELS;
                end
                else
                begin
                    nxt_sel = sel_ff + 2'h1;             // see (RULE_13)
                    nxt_ph  = pport_pkg::ST_IDLE;
                end
            end
            pport_pkg::ST_RELS:
            begin
                nxt_oe = 1'b0;                           // see (RULE_18)
                nxt_ph = pport_pkg::ST_READ;
            end
            pport_pkg::ST_READ:
            begin
                nxt_ioe[sel_ff] = 1'b0;                  // see (RULE_06) (RULE_18)
                nxt_ph = pport_pkg::ST_REDRV;
            end
            pport_pkg::ST_REDRV:
            begin
                nxt_ind[sel_ff] = bus_i;                 // see (RULE_05)
                nxt_sel = sel_ff + 2'h1;                 // see (RULE_13)
                nxt_ph  = pport_pkg::ST_IDLE;
            end
            default:
                nxt_ph = pport_pkg::ST_IDLE;
        endcase
        // Parked: a stray latch clock would load a port with a dead bus
        if (!par_en)
        begin
            nxt_ph   = pport_pkg::ST_IDLE;
            nxt_oe   = 1'b0;
            nxt_dclk = '0;
            nxt_cclk = '0;
            nxt_ioe  = '1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ph_ff   <= pport_pkg::ST_IDLE;
            sel_ff  <= 2'h0;
            bus_ff  <= 8'h0;
            oe_ff   <= 1'b0;
            dclk_ff <= '0;
            cclk_ff <= '0;
            ioe_ff  <= '1;
            ind_ff  <= '0;
        end
        else
        begin
            ph_ff   <= nxt_ph;
            sel_ff  <= nxt_sel;
            bus_ff  <= nxt_bus;
            oe_ff   <= nxt_oe;
            dclk_ff <= nxt_dclk;
            cclk_ff <= nxt_cclk;
            ioe_ff  <= nxt_ioe;
            ind_ff  <= nxt_ind;
        end
    end

    assign bus_o    = bus_ff;
    assign bus_oe   = oe_ff;
    assign data_clk = dclk_ff;
    assign ctl_clk  = cclk_ff;
    assign in_oe_n  = ioe_ff;
    assign in_data  = ind_ff;
endmodule // pport_host_mux

// ==== hdl/pport_map.svh ====
// Purpose: constants for the four-port parallel host multiplexer
// Assumes: 250 MHz system clock, one cycle per bus phase
// Notes:   control-phase bit positions follow the shared bus layout
// Function
// (RULE_01) Exactly one of five interface styles active
// (RULE_02) Style field selects parallel or host pin set
// (RULE_03) Parallel style disables shared-RAM and FIFO modes
// (RULE_04) Four port channels share pins via latches
// (RULE_05) Only host role of parallel protocol
// (RULE_06) Per-port data clock, control clock, output enable
// (RULE_07) Fixed data and control phase bit layout
// (RULE_08) Direction output follows reverse direction bit
// (RULE_09) Firmware output mirrors its control bit
// (RULE_10) Wrap mux output mirrors wrap select bit
// (RULE_11) Wrap capture is inverse of strobe
// (RULE_12) State machine drains FIFOs per port mode
// (RULE_13) Ports served round robin
// (RULE_14) Per-port four-byte register and four-byte FIFO
// (RULE_15) DMA word request when outbound register empties
// (RULE_16) Never two latch clocks active together
// (RULE_17) Four mode bits select port operating mode
// (RULE_18) Release bus before enable, drive after release
`ifndef PPORT_MAP_SVH
`define PPORT_MAP_SVH
`define STYLE_PARALLEL    3'h0
`define CTL_STROBE_BIT    7
`define CTL_AUTO_LINE_FEED_N_BIT    6
`define CTL_INIT_BIT      5
`define CTL_HSEL_BIT      4
`define CTL_DIR_BIT       3
`define CTL_FWOUT_BIT     2
`define CTL_WRAP_BIT      1
`define CTL_CAPT_BIT      0
`define STROBE_NS         500
`define CLK_NS            4
`define STROBE_CYC        ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define PORT_FIFO_DEPTH   4
`endif

// ==== hdl/pport_pkg.sv ====
// Purpose: types for the four-port parallel host multiplexer
// Assumes: nothing beyond the map header
// Notes:   mode bits packed as enhanced, extended, reverse, manual
package pport_pkg;
    typedef struct packed {
        logic enhanced;
        logic extended;
        logic reverse;
        logic manual;
    } mode_t;
    typedef struct packed {
        mode_t mode;
        logic  strobe_man_n;
        logic  auto_line_feed_n;
        logic  init_n;
        logic  host_select_in_n;
        logic  fw_out;
        logic  wrap_sel;
    } port_cfg_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_CLK   = 3'b011,
        ST_HOLD  = 3'b010,
        ST_RELS  = 3'b110,
        ST_READ  = 3'b111,
        ST_REDRV = 3'b101
    } phase_t;
endpackage

// ==== hdl/pport_chan.sv ====
// Purpose: one port channel: outbound register, FIFO, strobe sequencing
// Assumes: DMA writes a full word when dma_req is high
// Notes:   strobe timing is a minimum; serving jitter stretches it
`include "pport_map.svh"
module pport_chan #(
    parameter int STROBE_CYC = `STROBE_CYC
) (
    input  wire logic                 clk,        // System clock
    input  wire logic                 rst_n,      // Async reset, low
    input  wire logic                 enable,     // Parallel style active
    input  wire pport_pkg::port_cfg_t cfg,        // Port configuration
    input  wire logic                 busy,       // Peripheral busy
    input  wire logic                 wr_valid,   // Word write from DMA
    input  wire logic [31:0]          wr_data,    // Word data
    output logic                      dma_req,    // Outbound reg empty
    input  wire logic                 served,     // Control phase latched
    output logic [7:0]                data_out,   // Byte for data phase
    output logic                      strobe_n    // Strobe level
);
    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_SETUP = 2'b01,
        C_STB = 2'b11,
        C_HOLD = 2'b10
    } cst_t;
    logic [31:0] obr_ff, nxt_obr;
    logic        obr_full_ff, nxt_obr_full;
    logic [7:0]  fifo_ff [`PORT_FIFO_DEPTH], nxt_fifo [`PORT_FIFO_DEPTH];
    logic [2:0]  cnt_ff, nxt_cnt;
    logic [7:0]  dat_ff, nxt_dat;
    cst_t        st_ff, nxt_st;
    logic [15:0] tmr_ff, nxt_tmr;
    logic        auto_mode;
    assign auto_mode = cfg.mode == 4'h0;                 // see (RULE_17)
    assign dma_req   = enable && !obr_full_ff;           // see (RULE_15)
    assign data_out  = dat_ff;
    assign strobe_n  = cfg.mode.manual ? cfg.strobe_man_n : (st_ff != C_STB);

    always_comb
    begin
        nxt_obr      = obr_ff;
        nxt_obr_full = obr_full_ff;
        nxt_fifo     = fifo_ff;
        nxt_cnt      = cnt_ff;
        nxt_dat      = dat_ff;
        nxt_st       = st_ff;
        nxt_tmr      = tmr_ff;
        if (wr_valid && !obr_full_ff)
        begin
            nxt_obr      = wr_data;                      // see (RULE_14)
            nxt_obr_full = 1'b1;
        end
        else if (obr_full_ff && cnt_ff == 3'h0)
        begin
            for (int i = 0; i < `PORT_FIFO_DEPTH; i++)
                nxt_fifo[i] = obr_ff[8*i +: 8];
            nxt_cnt      = 3'h4;
            nxt_obr_full = 1'b0;
        end
        if (tmr_ff != 16'h0)
            nxt_tmr = tmr_ff - 16'h1;
        case (st_ff)
            C_IDLE:
                if (auto_mode && nxt_cnt != 3'h0 && !busy && served)
                begin
                    nxt_dat = nxt_fifo[0];               // see (RULE_12)
                    for (int i = 0; i < `PORT_FIFO_DEPTH - 1; i++)
                        nxt_fifo[i] = nxt_fifo[i+1];
                    nxt_cnt = nxt_cnt - 3'h1;
                    nxt_tmr = 16'(STROBE_CYC);
                    nxt_st  = C_SETUP;
                end
            C_SETUP:
                if (tmr_ff == 16'h0 && served)
                begin
                    nxt_tmr = 16'(STROBE_CYC);
                    nxt_st  = C_STB;
                end
            C_STB:
                if (tmr_ff == 16'h0 && served)
                begin
                    nxt_tmr = 16'(STROBE_CYC);
                    nxt_st  = C_HOLD;
                end
            C_HOLD:
                if (tmr_ff == 16'h0 && !busy && served)
                    nxt_st = C_IDLE;
            default:
                nxt_st = C_IDLE;
        endcase
        if (!enable)
            nxt_st = C_IDLE;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            obr_ff      <= 32'h0;
            obr_full_ff <= 1'b0;
            fifo_ff     <= '{default: 8'h0};
            cnt_ff      <= 3'h0;
            dat_ff      <= 8'h0;
            st_ff       <= C_IDLE;
            tmr_ff      <= 16'h0;
        end
        else
        begin
            obr_ff      <= nxt_obr;
            obr_full_ff <= nxt_obr_full;
            fifo_ff     <= nxt_fifo;
            cnt_ff      <= nxt_cnt;
            dat_ff      <= nxt_dat;
            st_ff       <= nxt_st;
            tmr_ff      <= nxt_tmr;
        end
    end
endmodule // pport_chan

// ==== verif/pport_chk.sv ====
// Purpose: port assertions for pport_host_mux
// Assumes: cfg changes only while the style is not parallel
// Notes:   attached to the top module by bind
module pport_chk #(
    parameter int NPORT      = 4,
    parameter int STROBE_CYC = 2
) (
    input wire logic                 clk,                   // Clock
    input wire logic                 rst_n,                 // Reset
    input wire logic [2:0]           interface_style_field, // Style
    input wire pport_pkg::port_cfg_t cfg [NPORT],           // Config
    input wire logic [NPORT-1:0]     wr_valid,              // Writes
    input wire logic [NPORT-1:0]     dma_req,               // Requests
    input wire logic                 parallel_pins_sel,     // Pin set
    input wire logic                 host_modes_en,         // Host modes
    input wire logic [7:0]           bus_o,                 // Bus
    input wire logic                 bus_oe,                // Bus enable
    input wire logic [NPORT-1:0]     data_clk,              // Data clks
    input wire logic [NPORT-1:0]     ctl_clk,               // Ctl clks
    input wire logic [NPORT-1:0]     in_oe_n                // Read enables
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic [NPORT-1:0] last_dclk_ff;
    logic [NPORT-1:0] nxt_last_dclk;
    // Forget the last port once the machine is parked
    always_comb
    begin
        nxt_last_dclk = last_dclk_ff;
        if (interface_style_field != 3'h0)
            nxt_last_dclk = '0;
        else if (data_clk != '0)
            nxt_last_dclk = data_clk;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            last_dclk_ff <= '0;
        else
            last_dclk_ff <= nxt_last_dclk;
    end
    chk_one_latch: assert property ($onehot0({data_clk, ctl_clk}))
        else $error("two latch clocks high");
    chk_pin_sel: assert property (parallel_pins_sel == (interface_style_field == 3'h0)
        && host_modes_en == !parallel_pins_sel) else $error("pin set wrong");
    chk_host_quiet: assert property ((interface_style_field != 3'h0)[*2] |-> !bus_oe
        && data_clk == '0 && ctl_clk == '0 && dma_req == '0) else $error("not parked");
    chk_latch_setup: assert property ((data_clk | ctl_clk) != '0 |-> bus_oe
        && $stable(bus_o)) else $error("bus moved at latch clock");
    chk_clk_width: assert property (((data_clk & $past(data_clk))
        | (ctl_clk & $past(ctl_clk))) == '0) else $error("latch clock too wide");
    chk_rr_order: assert property (data_clk != '0 && last_dclk_ff != '0 |->
        data_clk == {last_dclk_ff[NPORT-2:0], last_dclk_ff[NPORT-1]}) else $error("order");
    chk_rr_bound: assert property (disable iff (!rst_n || interface_style_field != 3'h0)
        data_clk != '0 |-> ##[4:7] data_clk != '0) else $error("slot too long");
    chk_capt_inv: assert property (ctl_clk != '0 |-> bus_o[0] == !bus_o[7])
        else $error("capture not inverse of strobe");
    chk_read_release: assert property (in_oe_n != '1 |-> !bus_oe && !$past(bus_oe))
        else $error("bus driven during read");
    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
        chk_ctl_fields: assert property (ctl_clk[p] |-> bus_o[6:1] ==
            {cfg[p].auto_line_feed_n, cfg[p].init_n, cfg[p].host_select_in_n,
            cfg[p].mode.reverse, cfg[p].fw_out, cfg[p].wrap_sel})
            else $error("control byte wrong");
        chk_dma_take: assert property (dma_req[p] && wr_valid[p] |=> !dma_req[p])
            else $error("request stayed up");
    end
    cov_read: cover property (in_oe_n != '1);
    cov_strobe: cover property (ctl_clk != '0 && !bus_o[7]);
    cov_take: cover property ((dma_req & wr_valid) != '0);
endmodule // pport_chk
bind pport_host_mux pport_chk #(.NPORT(NPORT), .STROBE_CYC(STROBE_CYC)) chk_i (.clk, .rst_n,
    .interface_style_field, .cfg, .wr_valid, .dma_req, .parallel_pins_sel, .host_modes_en,
    .bus_o, .bus_oe, .data_clk, .ctl_clk, .in_oe_n);

// ==== verif/pport_xcvr.sv ====
// Purpose: four latching transceivers with printers behind them
// Assumes: latches load while their clock is high at a clk edge
// Notes:   got logs the data latch at each strobe fall
module pport_xcvr (
    input  wire logic            clk,      // Clock
    input  wire logic            rst_n,    // Reset
    input  wire logic [7:0]      bus_o,    // Shared bus
    input  wire logic [3:0]      data_clk, // Data clks
    input  wire logic [3:0]      ctl_clk,  // Ctl clks
    input  wire logic [3:0]      in_oe_n,  // Read enables
    input  wire logic [3:0][7:0] inb,      // Cable bytes
    input  wire logic [7:0]      slow,     // Busy length
    output logic      [7:0]      bus_i,    // Inbound bus
    output logic      [3:0]      busy      // Busy lines
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] dlat [4];
    logic [7:0] clat [4];
    logic [7:0] cnt [4];
    logic [7:0] last;
    logic [7:0] got [4][$];
    // Undriven bus toggles so a stale capture cannot match
    always_comb
    begin
        bus_i = ~last;
        for (int p = 0; p < 4; p++)
            if (!in_oe_n[p])
                bus_i = inb[p];
    end
    always @(posedge clk or negedge rst_n)
    begin
        last <= bus_i;
        for (int p = 0; p < 4; p++)
            if (!rst_n)
            begin
                clat[p] = 8'hff;
                cnt[p] = 8'h00;
            end
            else if (ctl_clk[p])
            begin
                if (clat[p][7] && !bus_o[7])
                begin
                    got[p].push_back(dlat[p]);
                    cnt[p] = slow;
                end
                clat[p] = bus_o;
            end
            else if (data_clk[p])
                dlat[p] = bus_o;
            else if (cnt[p] != 8'h00)
                cnt[p] = cnt[p] - 8'h01;
        for (int p = 0; p < 4; p++)
            busy[p] <= (cnt[p] != 8'h00); // Design samples busy at the next edge
    end
endmodule // pport_xcvr

// ==== verif/tb.sv ====
// Purpose: random and corner tests for pport_host_mux
// Assumes: STROBE_CYC shortened to 2
// Notes:   cfg only changes while the machine is parked
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic [2:0]           style = 3'h0;
    pport_pkg::port_cfg_t cfg [4] = '{default: '1};
    logic [3:0]           busy, wr_valid = 4'h0, dma_req, data_clk, ctl_clk, in_oe_n;
    logic [31:0]          wr_data = 32'h0;
    logic                 pins, hmodes, bus_oe;
    logic [7:0]           bus_o, bus_i, slow = 8'h00;
    logic [3:0][7:0]      in_data, inb = '0;
    logic [7:0]           exp_q [4][$];
    logic [3:0]           mt [5] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'ha};
    int                   error_cnt = 0, checks = 0;
    always #2 clk = ~clk;
    pport_host_mux #(.NPORT(4), .STROBE_CYC(2)) uut (.clk, .rst_n,
        .interface_style_field(style), .cfg, .busy, .wr_valid, .wr_data, .dma_req,
        .parallel_pins_sel(pins), .host_modes_en(hmodes), .bus_o, .bus_oe, .bus_i,
        .data_clk, .ctl_clk, .in_oe_n, .in_data);
    pport_xcvr xcvr (.clk, .rst_n, .bus_o, .data_clk, .ctl_clk, .in_oe_n, .inb, .slow,
        .bus_i, .busy);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t %s got %h want %h", $time, m, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    function automatic pport_pkg::port_cfg_t rnd_cfg(input logic [3:0] m);
        pport_pkg::port_cfg_t c;
        c = 10'($urandom);
        c.mode = m;
        return c;
    endfunction
    function automatic logic [7:0] ctl_exp(input pport_pkg::port_cfg_t c);
        logic stb_n;
        stb_n = c.mode.manual ? c.strobe_man_n : 1'b1;
        return {stb_n, c.auto_line_feed_n, c.init_n, c.host_select_in_n,
            c.mode.reverse, c.fw_out, c.wrap_sel, ~stb_n};
    endfunction
    task automatic send(input int p, input logic [31:0] w);
        int n;
        n = 0;
        while (dma_req[p] !== 1'b1 && n < 5000)
        begin
            tick(1);
            n++;
        end
        wr_data = w;
        wr_valid[p] = 1'b1;
        tick(1);
        wr_valid[p] = 1'b0;
        chk(dma_req[p], 1'b0, "word not taken");
        for (int k = 0; k < 4; k++)
            exp_q[p].push_back(w[8*k+:8]);
    endtask
    initial
    begin
        #(40000 * 4);
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end
    initial
    begin
        int         n;
        void'($urandom(16));
        tick(12);
        rst_n = 1'b1;
        tick(1);
        chk(dma_req, 4'hf, "requests after reset");
        chk({pins, hmodes}, 2'b10, "pin set after reset");
        $display("reset test done");
        for (int s = 1; s < 8; s++)
        begin
            style = 3'(s);
            tick(2);
            chk(dma_req, 4'h0, "request in host style");
            chk({pins, hmodes, bus_oe}, 3'b010, "host style pins");
        end
        $display("style test done");
        for (int r = 0; r < 2; r++)
        begin
            for (int p = 0; p < 4; p++)
            begin
                cfg[p] = rnd_cfg(mt[(p + 4 * r) % 5]);
                inb[p] = 8'($urandom);
            end
            style = 3'h0;
            tick(60);
            for (int p = 0; p < 4; p++)
            begin
                chk(xcvr.clat[p], ctl_exp(cfg[p]), "control latch");
                if (cfg[p].mode.reverse)
                    chk(in_data[p], inb[p], "inbound byte");
            end
            style = 3'h2;
            tick(2);
        end
        $display("static mode test done");
        for (int p = 0; p < 4; p++)
        begin
            cfg[p] = rnd_cfg(4'h0);
            cfg[p].strobe_man_n = 1'b1;
            xcvr.got[p].delete();
        end
        style = 3'h0;
        for (int w = 0; w < 2; w++)
            for (int p = 0; p < 4; p++)
            begin
                slow = 8'($urandom_range(40));
                send(p, $urandom);
            end
        n = 0;
        while (n < 20000 && xcvr.got[0].size() + xcvr.got[1].size() + xcvr.got[2].size()
            + xcvr.got[3].size() < 32)
        begin
            tick(1);
            n++;
        end
        for (int p = 0; p < 4; p++)
        begin
            chk(xcvr.got[p].size(), 8, "byte count");
            foreach (xcvr.got[p][k])
                chk(xcvr.got[p][k], exp_q[p][k], "strobed byte");
        end
        $display("stream test done");
        test_done();
    end
endmodule // tb
